// ### hdl/sdwm_params.svh
`ifndef SDWM_PARAMS_SVH
`define SDWM_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SDWM_OFS_WD_CTRL 7'h00
`define SDWM_OFS_WD_STATUS 7'h05
`define SDWM_OFS_NV_CFG 7'h74

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDWM_CTRL_MODE_LSB 5
`define SDWM_CTRL_PER_LSB 0
`define SDWM_CFG_UV_LSB 4
`define SDWM_CFG_FORCED_BIT 3
`define SDWM_CFG_SWDEV_BIT 2
`define SDWM_CFG_VEXT_BIT 1
`define SDWM_CFG_SLEEP_BIT 0
`define SDWM_STAT_FORCED_BIT 3
`define SDWM_STAT_SWDEV_BIT 2

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define SDWM_MODE_AUTO 3'h1
`define SDWM_MODE_TIMEOUT 3'h2
`define SDWM_MODE_WINDOW 3'h4
`define SDWM_PER_DEFAULT 4'h4
`define SDWM_CFG_PRESET 8'h08
`define SDWM_CHIP_SLEEP 3'h1
`define SDWM_CHIP_STANDBY 3'h4
`define SDWM_CHIP_NORMAL 3'h7
`define SDWM_PHASE_OFF 2'h0
`define SDWM_PHASE_FIRST 2'h1
`define SDWM_PHASE_SECOND 2'h2
`define SDWM_RSRC_SLEEP_OVF 5'h0c
`define SDWM_RSRC_EARLY 5'h0e
`define SDWM_RSRC_OVF 5'h0f
`define SDWM_RSRC_ILLEGAL 5'h10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SDWM_CLK_HZ 50000000
`define SDWM_TICK_MS 1
`define SDWM_TICK_CYC (`SDWM_CLK_HZ / 1000 * `SDWM_TICK_MS)

`endif

// ### hdl/sdwm_pkg.sv
package sdwm_pkg;

  // Effective watchdog behaviour after all mode qualifiers.
  typedef enum logic [1:0] {
    SDWM_OFF,
    SDWM_WINDOW,
    SDWM_TIMEOUT
  } sdwm_behav_t;

  // Register access port from the serial front end.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } sdwm_reg_req_t;

  // Complete state of the watchdog block.
  typedef struct packed {
    logic [2:0] mode;
    logic [3:0] period;
    logic [7:0] cfg;
    logic [16:0] div;
    logic [12:0] ms;
    logic flag;
    logic rst;
    logic [4:0] rsrc;
    logic wake;
    logic spi_fail;
    logic [7:0] rdata;
  } sdwm_state_t;

endpackage : sdwm_pkg

// ### hdl/sdwm_core.sv
// Functional notes
// - Invalid mode or period code aborts write
// - Only redundant valid codes accepted
// - Forced run keeps watchdog off
// - Window code: window in Normal, timeout in Standby/Sleep
// - Timeout code: timeout in Normal/Standby/Sleep
// - Autonomous: timeout in Normal, Standby low
// - Autonomous with sw dev: always off
// - Sw dev loads autonomous after reset
// - Otherwise timeout code is default
// - Phase status off, first, second half
// - Status shows forced run, sw dev
// - Window overflow or early trigger resets
// - Late window trigger restarts timer
// - Timeout overflow flags, then resets
// - Sleep overflow raises wake-up event
// - Config bit3 forced run, bit2 sw dev
// - Start-up undervoltage threshold field drives regulator
// - Config bit0 disables Sleep support
// - Config writes need restricted access
// - Valid control write triggers and applies
// - Eight redundant periods, 128 ms default
// - Mode change in Normal forces reset
`timescale 1ns/1ps
`include "sdwm_params.svh"

module sdwm_core #(
  parameter int unsigned TICK_CYC = `SDWM_TICK_CYC
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Register access.
  input wire sdwm_pkg::sdwm_reg_req_t reg_req_i,
  input wire logic nv_unlock_i,
  output logic [7:0] reg_rdata_o,
  // Chip context.
  input wire logic [2:0] chip_mode_i,
  input wire logic host_interrupt_out_n_i,
  input wire logic sys_reset_i,
  input wire logic spi_fail_en_i,
  input wire logic wd_flag_clr_i,
  // Watchdog results.
  output logic [1:0] wd_phase_status_o,
  output logic wd_overflow_flag_o,
  output logic sys_reset_req_o,
  output logic [4:0] reset_source_code_o,
  output logic wake_event_o,
  output logic spi_fail_irq_o,
  // Configuration outputs.
  output logic forced_run_active_o,
  output logic sw_dev_active_o,
  output logic [1:0] main_reg_uv_threshold_o,
  output logic sleep_support_disable_o
);
  import sdwm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Maps a redundant period code to milliseconds; zero marks invalid.
  // Valid codes differ pairwise in two or more bits.
  function automatic logic [12:0] per_ms(input logic [3:0] code);
    logic [12:0] r;
    r = 13'h0000;
    case (code)
      4'h8: r = 13'h0008;
      4'h1: r = 13'h0010;
      4'h2: r = 13'h0020;
      4'hb: r = 13'h0040;
      4'h4: r = 13'h0080;
      4'hd: r = 13'h0100;
      4'he: r = 13'h0400;
      4'h7: r = 13'h1000;
      default: r = 13'h0000;
    endcase
    return r;
  endfunction : per_ms

  // Only one-hot mode codes are valid, so one flipped bit never
  // lands on another valid mode.
  function automatic logic mode_ok(input logic [2:0] code);
    logic r;
    r = 1'b0;
    case (code)
      `SDWM_MODE_AUTO: r = 1'b1;
      `SDWM_MODE_TIMEOUT: r = 1'b1;
      `SDWM_MODE_WINDOW: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : mode_ok

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sdwm_state_t st_q;
  sdwm_state_t st_d;
  sdwm_behav_t behav;
  logic fr_en;
  logic sd_en;
  logic [12:0] per_len;
  logic [12:0] half_len;
  logic tick;
  logic ovf;
  logic second_half;
  logic ctrl_wr;
  logic ctrl_ok;
  logic illegal;
  logic trig;
  logic [2:0] new_mode;
  logic [3:0] new_per;

  assign fr_en = st_q.cfg[`SDWM_CFG_FORCED_BIT];
  assign sd_en = st_q.cfg[`SDWM_CFG_SWDEV_BIT];
  assign new_mode = reg_req_i.wdata[`SDWM_CTRL_MODE_LSB +: 3];
  assign new_per = reg_req_i.wdata[`SDWM_CTRL_PER_LSB +: 4];

  // ----------------------------------------------------------------
  // Effective behaviour
  // ----------------------------------------------------------------

  // Resolve window, timeout or off from the qualifiers. Forced run
  // is checked first so that no mode code can override it.
  always_comb begin
    behav = SDWM_OFF;
    if (fr_en) begin
      behav = SDWM_OFF;
    end else begin
      case (st_q.mode)
        `SDWM_MODE_WINDOW: begin
          if (chip_mode_i == `SDWM_CHIP_NORMAL) begin
            behav = SDWM_WINDOW;
          end else if (chip_mode_i == `SDWM_CHIP_STANDBY ||
                       chip_mode_i == `SDWM_CHIP_SLEEP) begin
            behav = SDWM_TIMEOUT;
          end
        end
        `SDWM_MODE_TIMEOUT: begin
          if (chip_mode_i == `SDWM_CHIP_NORMAL ||
              chip_mode_i == `SDWM_CHIP_STANDBY ||
              chip_mode_i == `SDWM_CHIP_SLEEP) begin
            behav = SDWM_TIMEOUT;
          end
        end
        `SDWM_MODE_AUTO: begin
          if (sd_en) begin
            behav = SDWM_OFF;
          end else if (chip_mode_i == `SDWM_CHIP_NORMAL) begin
            behav = SDWM_TIMEOUT;
          end else if (chip_mode_i == `SDWM_CHIP_STANDBY &&
                       !host_interrupt_out_n_i) begin
            behav = SDWM_TIMEOUT;
          end
        end
        default: behav = SDWM_OFF;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Period timing
  // ----------------------------------------------------------------

  // The timer counts whole milliseconds, so a trigger lands with
  // up to one tick of jitter against the nominal boundaries.
  assign per_len = per_ms(st_q.period);
  assign half_len = {1'b0, per_len[12:1]};
  assign tick = (st_q.div == 17'(TICK_CYC - 1));
  assign ovf = tick && (st_q.ms + 13'h0001 >= per_len) &&
               (behav != SDWM_OFF);
  assign second_half = (st_q.ms >= half_len);

  // ----------------------------------------------------------------
  // Control register write decode
  // ----------------------------------------------------------------
  assign ctrl_wr = reg_req_i.wr &&
                   (reg_req_i.addr == `SDWM_OFS_WD_CTRL);
  assign ctrl_ok = mode_ok(new_mode) && (per_ms(new_per) != 13'h0000);
  assign illegal = ctrl_wr && ctrl_ok &&
                   (chip_mode_i == `SDWM_CHIP_NORMAL) &&
                   (new_mode != st_q.mode);
  assign trig = ctrl_wr && ctrl_ok && !illegal;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rst = 1'b0;
    st_d.wake = 1'b0;
    st_d.spi_fail = 1'b0;

    // Millisecond enable divider, free running.
    st_d.div = tick ? 17'h00000 : st_q.div + 17'h00001;

    // Timer advance; held at the period start while off.
    if (behav == SDWM_OFF) begin
      st_d.ms = 13'h0000;
    end else if (tick) begin
      st_d.ms = st_q.ms + 13'h0001;
    end

    // Overflow handling per behaviour.
    if (ovf) begin
      st_d.ms = 13'h0000;
      if (behav == SDWM_WINDOW) begin
        st_d.rst = 1'b1;
        st_d.rsrc = `SDWM_RSRC_OVF;
      end else if (st_q.flag) begin
        st_d.rst = 1'b1;
        st_d.rsrc = (chip_mode_i == `SDWM_CHIP_SLEEP) ?
                    `SDWM_RSRC_SLEEP_OVF : `SDWM_RSRC_OVF;
      end else begin
        st_d.flag = 1'b1;
      end
      if (behav == SDWM_TIMEOUT && chip_mode_i == `SDWM_CHIP_SLEEP) begin
        st_d.wake = 1'b1;
      end
    end

    // Control register write: trigger, reject or illegal access.
    if (ctrl_wr && !ctrl_ok) begin
      st_d.spi_fail = spi_fail_en_i;
    end else if (illegal) begin
      st_d.rst = 1'b1;
      st_d.rsrc = `SDWM_RSRC_ILLEGAL;
    end else if (trig) begin
      if (behav == SDWM_WINDOW && !second_half) begin
        st_d.rst = 1'b1;
        st_d.rsrc = `SDWM_RSRC_EARLY;
      end
      st_d.mode = new_mode;
      st_d.period = new_per;
      st_d.ms = 13'h0000;
    end

    // Software clear of the flag loses against a same-cycle set.
    if (wd_flag_clr_i && !(ovf && behav == SDWM_TIMEOUT)) begin
      st_d.flag = 1'b0;
    end

    // Restricted-access write of the non-volatile configuration.
    if (reg_req_i.wr && nv_unlock_i &&
        reg_req_i.addr == `SDWM_OFS_NV_CFG) begin
      st_d.cfg = {2'h0, reg_req_i.wdata[5:0]};
    end

    // A system reset, own or external, restarts the watchdog with
    // the mode default chosen by the development setting.
    if (st_q.rst || sys_reset_i) begin
      st_d.mode = sd_en ? `SDWM_MODE_AUTO : `SDWM_MODE_TIMEOUT;
      st_d.period = `SDWM_PER_DEFAULT;
      st_d.ms = 13'h0000;
    end

    // Registered read data; unmapped offsets read as zero.
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `SDWM_OFS_WD_CTRL: begin
          st_d.rdata = {st_q.mode, 1'b0, st_q.period};
        end
        `SDWM_OFS_WD_STATUS: begin
          st_d.rdata = {4'h0, fr_en, sd_en, wd_phase_status_o};
        end
        `SDWM_OFS_NV_CFG: st_d.rdata = st_q.cfg;
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // The configuration comes up at its factory preset; a real part
  // would load it from non-volatile cells at this point.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.mode <= `SDWM_MODE_TIMEOUT;
      st_q.period <= `SDWM_PER_DEFAULT;
      st_q.cfg <= `SDWM_CFG_PRESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  always_comb begin
    if (behav == SDWM_OFF) begin
      wd_phase_status_o = `SDWM_PHASE_OFF;
    end else if (second_half) begin
      wd_phase_status_o = `SDWM_PHASE_SECOND;
    end else begin
      wd_phase_status_o = `SDWM_PHASE_FIRST;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign wd_overflow_flag_o = st_q.flag;
  assign sys_reset_req_o = st_q.rst;
  assign reset_source_code_o = st_q.rsrc;
  assign wake_event_o = st_q.wake;
  assign spi_fail_irq_o = st_q.spi_fail;
  assign forced_run_active_o = fr_en;
  assign sw_dev_active_o = sd_en;
  assign main_reg_uv_threshold_o = st_q.cfg[`SDWM_CFG_UV_LSB +: 2];
  assign sleep_support_disable_o = st_q.cfg[`SDWM_CFG_SLEEP_BIT];

endmodule : sdwm_core

// ### test/sdwm_checker.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker of the watchdog core
// ----------------------------------------------------------------
module sdwm_checker (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Requests and context.
  input wire sdwm_pkg::sdwm_reg_req_t reg_req_i,
  input wire logic nv_unlock_i,
  input wire logic spi_fail_en_i,
  input wire logic [2:0] chip_mode_i,
  // Results.
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] wd_phase_status_o,
  input wire logic spi_fail_irq_o,
  input wire logic wake_event_o,
  input wire logic sys_reset_req_o,
  input wire logic [4:0] reset_source_code_o,
  input wire logic forced_run_active_o,
  input wire logic sw_dev_active_o,
  input wire logic [1:0] main_reg_uv_threshold_o,
  input wire logic sleep_support_disable_o
);
  import sdwm_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic ctl_wr;
  logic cfg_wr;
  // Decoded writes keep the properties short.
  assign ctl_wr = reg_req_i.wr && reg_req_i.addr == 7'h00;
  assign cfg_wr = reg_req_i.wr && reg_req_i.addr == 7'h74;
  a_phase_legal: assert property (
    wd_phase_status_o != 2'h3) else $error("reserved phase code");
  a_forced_off: assert property (
    forced_run_active_o |-> wd_phase_status_o == 2'h0)
    else $error("watchdog runs in forced run");
  a_status_read: assert property (
    reg_req_i.rd && reg_req_i.addr == 7'h05 |=> reg_rdata_o == {4'h0,
    $past(forced_run_active_o), $past(sw_dev_active_o),
    $past(wd_phase_status_o)}) else $error("status read wrong");
  a_bad_mode_fail: assert property (
    ctl_wr && reg_req_i.wdata[7:5] == 3'h3 && spi_fail_en_i
    |=> spi_fail_irq_o) else $error("no fail pulse");
  a_fail_cause: assert property (
    spi_fail_irq_o |-> $past(spi_fail_en_i) && $past(ctl_wr))
    else $error("fail pulse without cause");
  a_wake_sleep: assert property (
    wake_event_o |-> $past(chip_mode_i) == 3'h1)
    else $error("wake outside sleep");
  a_reset_source: assert property (
    sys_reset_req_o |=> reset_source_code_o inside
    {5'h0c, 5'h0e, 5'h0f, 5'h10}) else $error("bad reset source");
  a_write_restart: assert property (
    ctl_wr && reg_req_i.wdata == 8'h48 && chip_mode_i == 3'h4 &&
    !forced_run_active_o ##1 chip_mode_i == 3'h4
    |-> wd_phase_status_o == 2'h1) else $error("no restart");
  a_cfg_locked: assert property (
    cfg_wr && !nv_unlock_i |=> $stable(forced_run_active_o) &&
    $stable(sw_dev_active_o)) else $error("locked config changed");
  a_cfg_fields: assert property (
    cfg_wr && nv_unlock_i |=> {main_reg_uv_threshold_o,
    forced_run_active_o, sw_dev_active_o, sleep_support_disable_o} ==
    {$past(reg_req_i.wdata[5:2]), $past(reg_req_i.wdata[0])})
    else $error("config fields wrong");
  c_reset: cover property (sys_reset_req_o);
  c_wake: cover property (wake_event_o);
  c_fail: cover property (spi_fail_irq_o);
endmodule : sdwm_checker

// ### test/sdwm_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host model driving the register port
// ----------------------------------------------------------------
module sdwm_host (
  // Clock and read data.
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  // Register request.
  output sdwm_pkg::sdwm_reg_req_t req_o
);
  import sdwm_pkg::*;
  // Idle from time zero, so nothing is taken during reset.
  initial req_o = '0;
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    #1;
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk_i);
    #1;
    req_o = '0;
  endtask : wr
  // Read data is registered, so it is taken one edge after the strobe.
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge core_clk_i);
    #1;
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    #1;
    req_o = '0;
    v = rdata_i;
  endtask : rd
endmodule : sdwm_host

// ### test/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Watchdog core testbench
// ----------------------------------------------------------------
module tb_top;
  import sdwm_pkg::*;
  logic core_clk_i, rst_n_i, nv_unlock_i, sys_reset_i, spi_fail_en_i;
  logic wd_flag_clr_i, host_interrupt_out_n_i, bad;
  logic [2:0] chip_mode_i;
  sdwm_reg_req_t reg_req_i;
  logic [7:0] reg_rdata_o;
  logic [1:0] wd_phase_status_o, main_reg_uv_threshold_o;
  logic [4:0] reset_source_code_o;
  logic wd_overflow_flag_o, sys_reset_req_o, wake_event_o, spi_fail_irq_o;
  logic forced_run_active_o, sw_dev_active_o, sleep_support_disable_o;
  int fails = 0, n_tests = 0, n_fail = 0, n_rst = 0, n_wake = 0, b;
  // Tables: modes, chip modes, pin levels and expected watchdog activity.
  localparam logic [8:0] MODES = {3'h1, 3'h2, 3'h4};
  localparam logic [14:0] CHIPS = {3'h0, 3'h1, 3'h4, 3'h4, 3'h7};
  localparam logic [4:0] INTN = 5'b11011;
  localparam logic [14:0] EXP = {5'b00101, 5'b01111, 5'b01111};
  localparam logic [15:0] VP = 16'h6996;
  localparam logic [7:0] VM = 8'h16;
  sdwm_core #(.TICK_CYC(10)) i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .nv_unlock_i(nv_unlock_i), .reg_rdata_o(reg_rdata_o),
    .chip_mode_i(chip_mode_i), .sys_reset_i(sys_reset_i),
    .host_interrupt_out_n_i(host_interrupt_out_n_i),
    .spi_fail_en_i(spi_fail_en_i), .wd_flag_clr_i(wd_flag_clr_i),
    .wd_phase_status_o(wd_phase_status_o),
    .wd_overflow_flag_o(wd_overflow_flag_o),
    .sys_reset_req_o(sys_reset_req_o), .wake_event_o(wake_event_o),
    .reset_source_code_o(reset_source_code_o),
    .spi_fail_irq_o(spi_fail_irq_o),
    .forced_run_active_o(forced_run_active_o),
    .sw_dev_active_o(sw_dev_active_o),
    .main_reg_uv_threshold_o(main_reg_uv_threshold_o),
    .sleep_support_disable_o(sleep_support_disable_o));
  sdwm_host i_host (.core_clk_i(core_clk_i), .rdata_i(reg_rdata_o),
    .req_o(reg_req_i));
  // Free-running 50 MHz clock.
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // Pulses are counted, so a check never depends on catching one cycle.
  always @(posedge core_clk_i) begin
    if (spi_fail_irq_o === 1'b1) n_fail <= n_fail + 1;
    if (sys_reset_req_o === 1'b1) n_rst <= n_rst + 1;
    if (wake_event_o === 1'b1) n_wake <= n_wake + 1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : step
  task automatic chk(input string s, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [6:0] a, input logic [7:0] e, string s);
    logic [7:0] v;
    i_host.rd(a, v);
    chk(s, e, v);
  endtask : rchk
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // The whole sequence needs well under 5000 cycles.
  initial begin
    #200us;
    fails++;
    end_of_test();
  end
  initial begin
    {rst_n_i, nv_unlock_i, sys_reset_i, wd_flag_clr_i} = 4'h0;
    {spi_fail_en_i, host_interrupt_out_n_i} = 2'h3;
    chip_mode_i = 3'h4;
    step(8);
    rst_n_i = 1'b1;
    rchk(7'h74, 8'h08, "config preset");
    rchk(7'h05, 8'h08, "status preset");
    rchk(7'h00, 8'h44, "control default");
    rchk(7'h33, 8'h00, "unmapped read");
    i_host.wr(7'h74, 8'h00);
    rchk(7'h74, 8'h08, "locked config");
    nv_unlock_i = 1'b1;
    i_host.wr(7'h74, 8'h31);
    chk("uv and sleep", 8'h07,
        8'({main_reg_uv_threshold_o, sleep_support_disable_o}));
    i_host.wr(7'h74, 8'h00);
    // Every mode code, then every period code.
    for (int i = 0; i < 24; i++) begin
      b = n_fail;
      bad = (i < 8) ? !VM[i] : !VP[i[3:0] ^ 4'h8];
      if (i < 8) i_host.wr(7'h00, {i[2:0], 5'h04});
      else i_host.wr(7'h00, {4'h4, i[3:0] ^ 4'h8});
      step(1);
      chk("invalid code", {7'h00, bad}, 8'(n_fail - b));
    end
    rchk(7'h00, 8'h4e, "control kept");
    spi_fail_en_i = 1'b0;
    b = n_fail;
    i_host.wr(7'h00, 8'h69);
    step(1);
    chk("masked fail", 8'h00, 8'(n_fail - b));
    // Timeout run with 8 ms period: half point, flag, then reset.
    i_host.wr(7'h00, 8'h48);
    step(30);
    chk("first half", 8'h01, wd_phase_status_o);
    step(25);
    chk("second half", 8'h02, wd_phase_status_o);
    step(45);
    chk("overflow flag", 8'h01, wd_overflow_flag_o);
    b = n_rst;
    step(80);
    chk("second overflow", 8'h01, 8'(n_rst - b));
    chk("overflow source", 8'h0f, reset_source_code_o);
    rchk(7'h00, 8'h44, "reloaded control");
    wd_flag_clr_i = 1'b1;
    step(1);
    wd_flag_clr_i = 1'b0;
    chk("flag cleared", 8'h00, wd_overflow_flag_o);
    for (int m = 0; m < 3; m++) begin
      for (int j = 0; j < 5; j++) begin
        chip_mode_i = 3'h4;
        host_interrupt_out_n_i = 1'b1;
        i_host.wr(7'h00, {MODES[3*m +: 3], 5'h04});
        chip_mode_i = CHIPS[3*j +: 3];
        host_interrupt_out_n_i = INTN[j];
        step(1);
        chk("mode table", 8'(EXP[5*m+j]),
            8'(wd_phase_status_o != 2'h0));
      end
    end
    // Window run in Normal: late trigger, early trigger, mode change.
    chip_mode_i = 3'h4;
    i_host.wr(7'h00, 8'h88);
    chip_mode_i = 3'h7;
    b = n_rst;
    step(55);
    i_host.wr(7'h00, 8'h88);
    chk("late trigger", 8'h01, {6'(n_rst - b), wd_phase_status_o});
    i_host.wr(7'h00, 8'h88);
    step(2);
    chk("early source", 8'h0e, reset_source_code_o);
    i_host.wr(7'h00, 8'h88);
    step(2);
    chk("illegal source", 8'h10, reset_source_code_o);
    chip_mode_i = 3'h1;
    b = n_wake;
    i_host.wr(7'h00, 8'h48);
    step(100);
    chk("sleep wake", 8'h01, 8'(n_wake - b));
    step(80);
    chk("sleep source", 8'h0c, reset_source_code_o);
    chip_mode_i = 3'h4;
    i_host.wr(7'h74, 8'h04);
    sys_reset_i = 1'b1;
    step(1);
    sys_reset_i = 1'b0;
    rchk(7'h00, 8'h24, "sw dev default");
    chip_mode_i = 3'h7;
    rchk(7'h05, 8'h04, "sw dev status");
    chip_mode_i = 3'h4;
    i_host.wr(7'h00, 8'h44);
    rchk(7'h05, 8'h05, "test enable");
    end_of_test();
  end
endmodule : tb_top
bind sdwm_core sdwm_checker i_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
  .nv_unlock_i(nv_unlock_i), .spi_fail_en_i(spi_fail_en_i),
  .chip_mode_i(chip_mode_i), .reg_rdata_o(reg_rdata_o),
  .wd_phase_status_o(wd_phase_status_o), .spi_fail_irq_o(spi_fail_irq_o),
  .wake_event_o(wake_event_o), .sys_reset_req_o(sys_reset_req_o),
  .reset_source_code_o(reset_source_code_o),
  .forced_run_active_o(forced_run_active_o),
  .sw_dev_active_o(sw_dev_active_o),
  .main_reg_uv_threshold_o(main_reg_uv_threshold_o),
  .sleep_support_disable_o(sleep_support_disable_o));
